// ===== tfc_pkg.sv
// Notes on behaviour
// R01 - After power-up reset the tuned frequency holds 15.00000 MHz before any knob input.
// R02 - A momentary preset request reloads the tuned frequency to 15.00000 MHz from any value.
// R03 - Each step moves the frequency by the selected rate: 10 Hz, 100 Hz, 1 kHz or 10 kHz, up or down.
// R04 - The direction level is high for clockwise turning and low for counterclockwise; up on high.
// R05 - Each short positive step pulse advances the selected counter by exactly one step.
// R06 - In the beat-oscillator position steps change a separate offset over -8.0 to +8.0 instead.
// R07 - In offset mode the offset counts up for clockwise and down for counterclockwise as well.
// R08 - The offset-mode select output is low whenever the knob tunes the receiver frequency.
// R09 - A 3-bit band code is all ones for 0-3.99 MHz and drops by one per 4 MHz band to zero.
// R10 - At a tuned frequency of zero the first oscillator divider ratio is 4291.
// R11 - At 15.00000 MHz the second oscillator programmable counter divides by 20.
// R12 - The programmable loop output is 200 kHz at 15.00099 MHz and 210 kHz at 15.00000 MHz.
// R13 - At zero offset the offset synthesizer counters divide by 455 after a fixed prescale of ten.
// R14 - The second oscillator reference divider divides by 800 and its prescaler by 100.
// R15 - Step and direction are synchronised first; each step gives one update with decade carries.
`default_nettype none

package tfc_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_FREQ    = 8'h04;
	localparam logic [7:0] ADR_OFFSET  = 8'h08;
	localparam logic [7:0] ADR_BAND    = 8'h0C;
	localparam logic [7:0] ADR_LO1     = 8'h10;
	localparam logic [7:0] ADR_LO2     = 8'h14;
	localparam logic [7:0] ADR_BFODIV  = 8'h18;
	localparam logic [7:0] ADR_FIXDIV  = 8'h1C;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int CTRL_RATE_LSB = 0;
	localparam int CTRL_PRESET   = 3;
	localparam int LO2_LOOP_LSB  = 16;
	localparam int FIX_PRE_LSB   = 16;

	// Rate selector positions
	localparam logic [2:0] RATE_10HZ  = 3'h0;
	localparam logic [2:0] RATE_100HZ = 3'h1;
	localparam logic [2:0] RATE_1KHZ  = 3'h2;
	localparam logic [2:0] RATE_10KHZ = 3'h3;
	localparam logic [2:0] RATE_BFO   = 3'h4;
	localparam logic [2:0] RATE_RESET = RATE_10HZ;

	// ----------------------------------------
	// Frequency counter: digit 0 = 10 Hz ... digit 6 = 10 MHz
	// ----------------------------------------
	localparam int         NUM_DIGITS = 7;
	localparam logic [3:0] TOP_DIGIT_MAX = 4'h2;
	localparam logic [3:0] PRESET_D6  = 4'h1;
	localparam logic [3:0] PRESET_D5  = 4'h5;

	// ----------------------------------------
	// Synthesizer figures
	// ----------------------------------------
	localparam logic [12:0] LO1_DIV_ZERO  = 13'h10C3;  // 4291
	localparam logic [7:0]  LO2_DIV_BASE  = 8'h14;     // 20
	localparam logic [7:0]  LOOP_KHZ_BASE = 8'hD2;     // 210
	localparam logic [13:0] LOOP_SPAN     = 14'h000A;  // 10 kHz swing
	localparam logic [13:0] LOW2_MAX      = 14'h0063;  // 99
	localparam logic [9:0]  BFO_DIV_ZERO  = 10'h1C7;   // 455
	localparam logic [9:0]  BFO_PRESCALE  = 10'h00A;   // 10
	localparam logic [9:0]  REF_DIV       = 10'h320;   // 800
	localparam logic [6:0]  PRESCALE_DIV  = 7'h64;     // 100
	localparam logic signed [7:0] BFO_LIMIT = 8'sh50;  // 8.0 in tenths

	// Output values matching the 15.00000 MHz preset
	localparam logic [2:0]  BAND_RESET   = 3'h4;
	localparam logic [12:0] LO1_RESET    = 13'h169F;  // 4291 + 1500
	localparam logic [7:0]  LO2_RESET    = LO2_DIV_BASE;
	localparam logic [7:0]  LOOP_RESET   = LOOP_KHZ_BASE;

endpackage : tfc_pkg

`default_nettype wire

// ===== tfc_sync.sv
`default_nettype none

// ----------------------------------------
// Two-flop synchroniser with rising edge pulse
// ----------------------------------------
module tfc_sync (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic din,
	output var  logic level,
	output var  logic rise
);
	logic meta;
	logic prev;

	// First flop feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta  <= 1'b0;
			level <= 1'b0;
			prev  <= 1'b0;
		end else begin
			meta  <= din;
			level <= meta;
			prev  <= level;
		end
	end

	// One pulse per input rise, however long it lasts
	assign rise = level & ~prev;

endmodule : tfc_sync

`default_nettype wire

// ===== tfc_digit.sv
`default_nettype none

// ----------------------------------------
// One decade of the up/down frequency counter
// ----------------------------------------
module tfc_digit (
	input  wire logic [3:0] cur,
	input  wire logic       inc,
	input  wire logic       up,
	output var  logic [3:0] nxt,
	output var  logic       cout
);
	// Carry on 9 -> 0, borrow on 0 -> 9
	always_comb begin
		nxt  = cur;
		cout = 1'b0;
		if (inc) begin
			if (up) begin
				nxt  = (cur == 4'h9) ? 4'h0 : 4'(cur + 4'h1);
				cout = (cur == 4'h9);
			end else begin
				nxt  = (cur == 4'h0) ? 4'h9 : 4'(cur - 4'h1);
				cout = (cur == 4'h0);
			end
		end
	end

endmodule : tfc_digit

`default_nettype wire

// ===== tfc_top.sv
// Design decisions made here: register access over Wishbone and the address map.
`default_nettype none

module tfc_top (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        knob_dir,
	input  wire logic        knob_step,
	input  wire logic        preset_in,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	output var  logic        band_code_msb,
	output var  logic        band_code_mid,
	output var  logic        band_code_lsb,
	output var  logic        bfo_select,
	output var  logic        tune_dir,
	output var  logic [12:0] lo1_div,
	output var  logic [7:0]  lo2_div,
	output var  logic [7:0]  loop_khz,
	output var  logic [9:0]  bfo_div
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Two BCD digits to binary
	function automatic logic [6:0] bcd2(input logic [3:0] hi, input logic [3:0] lo);
		bcd2 = 7'(7'(hi) * 7'd10 + 7'(lo));
	endfunction : bcd2

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic dir_s;
	logic step_evt;
	logic preset_evt;

	tfc_sync u_sync_dir (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (knob_dir),
		.level (dir_s),
		.rise  ()
	);

	tfc_sync u_sync_step (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (knob_step),
		.level (),
		.rise  (step_evt)
	);

	tfc_sync u_sync_preset (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (preset_in),
		.level (),
		.rise  (preset_evt)
	);

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	logic [2:0]  rate;
	logic        sw_preset;
	logic        wb_req;
	logic        wb_wr_ctrl;
	logic [3:0]  dig [tfc_pkg::NUM_DIGITS];
	logic signed [7:0] offset;
	logic [31:0] next_rdata;

	// Single cycle answer, ack drops the cycle after
	assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == tfc_pkg::ADR_CTRL);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	// Read mux; unmapped words read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			tfc_pkg::ADR_CTRL:   next_rdata[2:0] = rate;
			tfc_pkg::ADR_FREQ:   next_rdata[27:0] = {dig[6], dig[5], dig[4], dig[3],
			                                         dig[2], dig[1], dig[0]};
			tfc_pkg::ADR_OFFSET: next_rdata = 32'(offset);
			tfc_pkg::ADR_BAND:   next_rdata[2:0] = {band_code_msb, band_code_mid,
			                                       band_code_lsb};
			tfc_pkg::ADR_LO1:    next_rdata[12:0] = lo1_div;
			tfc_pkg::ADR_LO2:    next_rdata = {8'h00, loop_khz, 8'h00, lo2_div};
			tfc_pkg::ADR_BFODIV: next_rdata[9:0] = bfo_div;
			tfc_pkg::ADR_FIXDIV: next_rdata = {9'h000, tfc_pkg::PRESCALE_DIV,
			                                   6'h00, tfc_pkg::REF_DIV}; // R14
			default:             next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Preset bit is a write-one pulse and never reads back
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rate      <= tfc_pkg::RATE_RESET;
			sw_preset <= 1'b0;
		end else begin
			sw_preset <= wb_wr_ctrl & wb_dat_i[tfc_pkg::CTRL_PRESET];
			if (wb_wr_ctrl && wb_dat_i[2:0] <= tfc_pkg::RATE_BFO)
				rate <= wb_dat_i[2:0];
		end
	end

	logic bfo_mode;
	logic tune_step;
	logic bfo_step;

	assign bfo_mode  = (rate == tfc_pkg::RATE_BFO);
	assign tune_step = step_evt & ~bfo_mode;  // R05
	assign bfo_step  = step_evt & bfo_mode;   // R06

	// ----------------------------------------
	// Decade frequency counter
	// ----------------------------------------
	logic [6:0] inc;
	logic [6:0] cy;
	logic [6:0] cin;
	logic [3:0] nd [tfc_pkg::NUM_DIGITS];
	logic       step_ok;

	assign cin = {cy[5:0], 1'b0};

	genvar gi;
	for (gi = 0; gi < tfc_pkg::NUM_DIGITS; gi++) begin : g_dig
		// Step enters at the rate digit, carries ripple upward
		assign inc[gi] = (tune_step & ({1'b0, rate[1:0]} == 3'(gi))) | cin[gi]; // R03
		tfc_digit u_digit (
			.cur  (dig[gi]),
			.inc  (inc[gi]),
			.up   (dir_s),  // R04
			.nxt  (nd[gi]),
			.cout (cy[gi])
		);
	end

	// Stops at 0 and 29.99999 MHz rather than wrapping
	assign step_ok = ~cy[6] & (nd[6] <= tfc_pkg::TOP_DIGIT_MAX);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < tfc_pkg::NUM_DIGITS; i++)
				dig[i] <= 4'h0;
			dig[6] <= tfc_pkg::PRESET_D6;  // R01
			dig[5] <= tfc_pkg::PRESET_D5;  // R01
		end else if (preset_evt || sw_preset) begin
			for (int i = 0; i < tfc_pkg::NUM_DIGITS; i++)
				dig[i] <= 4'h0;
			dig[6] <= tfc_pkg::PRESET_D6;  // R02
			dig[5] <= tfc_pkg::PRESET_D5;  // R02
		end else if (tune_step && step_ok) begin
			for (int i = 0; i < tfc_pkg::NUM_DIGITS; i++)
				dig[i] <= nd[i];  // R15
		end
	end

	// ----------------------------------------
	// Beat-oscillator offset, tenths of kHz
	// ----------------------------------------
	// Held separately so switching modes never disturbs the tuning
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			offset <= 8'sh00;
		end else if (bfo_step) begin
			if (dir_s && offset < tfc_pkg::BFO_LIMIT)
				offset <= 8'(offset + 8'sh01);  // R07
			else if (!dir_s && offset > -tfc_pkg::BFO_LIMIT)
				offset <= 8'(offset - 8'sh01);  // R07
		end
	end

	// ----------------------------------------
	// Derived synthesizer values
	// ----------------------------------------
	logic [6:0]  mhz;
	logic [6:0]  low2;
	logic [12:0] f10k;
	logic [2:0]  next_band;
	logic [12:0] next_lo1;
	logic [7:0]  next_lo2;
	logic [7:0]  next_loop;
	logic [9:0]  next_bfo_div;

	assign mhz  = bcd2(dig[6], dig[5]);
	assign low2 = bcd2(dig[1], dig[0]);
	assign f10k = 13'(13'(bcd2(dig[6], dig[5])) * 13'd100 + 13'(bcd2(dig[4], dig[3])));

	assign next_band    = 3'(3'd7 - 3'(mhz >> 2));                       // R09
	assign next_lo1     = 13'(tfc_pkg::LO1_DIV_ZERO + f10k);              // R10
	assign next_lo2     = 8'(tfc_pkg::LO2_DIV_BASE + 8'(low2));           // R11
	assign next_loop    = 8'(tfc_pkg::LOOP_KHZ_BASE
	                      - 8'((14'(low2) * tfc_pkg::LOOP_SPAN) / tfc_pkg::LOW2_MAX)); // R12
	assign next_bfo_div = 10'(tfc_pkg::BFO_DIV_ZERO + {{2{offset[7]}}, offset}); // R13

	// Registered outputs, one cycle behind the counters
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{band_code_msb, band_code_mid, band_code_lsb} <= tfc_pkg::BAND_RESET;
			lo1_div  <= tfc_pkg::LO1_RESET;
			lo2_div  <= tfc_pkg::LO2_RESET;
			loop_khz <= tfc_pkg::LOOP_RESET;
			bfo_div  <= tfc_pkg::BFO_DIV_ZERO;
		end else begin
			{band_code_msb, band_code_mid, band_code_lsb} <= next_band;  // R09
			lo1_div  <= next_lo1;
			lo2_div  <= next_lo2;
			loop_khz <= next_loop;
			bfo_div  <= next_bfo_div;
		end
	end

	// Mode and direction outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bfo_select <= 1'b0;
			tune_dir   <= 1'b0;
		end else begin
			bfo_select <= bfo_mode;  // R08
			tune_dir   <= dir_s;     // R04
		end
	end

endmodule : tfc_top

`default_nettype wire

// ===== tfc_top_properties.sv
`default_nettype none

// ------------
// Port checker
// ------------
module tfc_top_properties (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        knob_dir,
	input wire logic        preset_in,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        band_code_msb,
	input wire logic        band_code_mid,
	input wire logic        band_code_lsb,
	input wire logic        bfo_select,
	input wire logic        tune_dir,
	input wire logic [12:0] lo1_div,
	input wire logic [7:0]  lo2_div,
	input wire logic [7:0]  loop_khz,
	input wire logic [9:0]  bfo_div
);
	logic [12:0] band_want;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Band from the first divider: 400 steps of 10 kHz per band
	assign band_want = 13'h7 - (lo1_div - tfc_pkg::LO1_DIV_ZERO) / 13'h190;

	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_band_code_map: assert property (
		{band_code_msb, band_code_mid, band_code_lsb} == band_want[2:0])
		else $error("band code does not match frequency");
	a_loop_at_base: assert property (lo2_div == 8'h14 |-> loop_khz == 8'hD2)
		else $error("loop not 210 kHz at low digits zero");
	a_loop_at_top: assert property (lo2_div == 8'h77 |-> loop_khz == 8'hC8)
		else $error("loop not 200 kHz at low digits 99");
	// Five quiet samples: three cover the three-flop delay, the other two the reset release edge
	a_dir_follows_knob: assert property ($stable(knob_dir) [*5] |-> tune_dir == knob_dir)
		else $error("direction output does not follow knob");
	a_preset_reload: assert property ($rose(preset_in) |-> ##5
		lo1_div == tfc_pkg::LO1_RESET && lo2_div == tfc_pkg::LO2_RESET)
		else $error("preset did not reload frequency");
	a_offset_in_bfo: assert property ($changed(bfo_div) |->
		$past(bfo_select) || $past(bfo_select, 2))
		else $error("offset moved outside offset mode");
endmodule : tfc_top_properties

`default_nettype wire

// ===== tfc_knob_model.sv
`default_nettype none

// ------------------
// Knob detent model
// ------------------
module tfc_knob_model (
	input  wire logic mclk,
	input  wire logic go,
	input  wire logic dir,
	output var  logic knob_dir,
	output var  logic knob_step,
	output var  logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ph = 3'h0;

	initial knob_dir = 1'h0;
	initial knob_step = 1'h0;

	// Direction settles two edges before the pulse; long low gap after
	always @(posedge mclk) begin
		if (ph != 3'h0 || go)
			ph <= ph + 3'h1;
		if (ph == 3'h0 && go)
			knob_dir <= dir;
		knob_step <= (ph == 3'h2 || ph == 3'h3);
	end
	assign busy = (ph != 3'h0);
endmodule : tfc_knob_model

`default_nettype wire

// ===== tuning_frequency_control_tb_top.sv
`default_nettype none

// --------------------
// Tuning control bench
// --------------------
module tuning_frequency_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'h0, rst_n = 1'h0, preset_in = 1'h0, go = 1'h0, dir = 1'h0;
	logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0]  wb_adr_i = 8'h0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [12:0] lo1_div;
	logic [7:0]  lo2_div, loop_khz;
	logic [9:0]  bfo_div;
	logic [2:0]  rate = 3'h0;
	logic        knob_dir, knob_step, busy, wb_ack_o, bfo_select, tune_dir;
	logic        band_code_msb, band_code_mid, band_code_lsb;
	int          error_cnt = 0, cmp_count = 0, seed = 32'h03B9, f10 = 32'h16E360, off = 0, i;

	always #5 mclk = ~mclk;

	tfc_top uut (.mclk, .rst_n, .knob_dir, .knob_step, .preset_in, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .band_code_msb,
		.band_code_mid, .band_code_lsb, .bfo_select, .tune_dir, .lo1_div, .lo2_div,
		.loop_khz, .bfo_div);
	tfc_knob_model knob (.mclk, .go, .dir, .knob_dir, .knob_step, .busy);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Classic cycle; a dead slave is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb

	task automatic setr(input logic [2:0] r);
		rate = r;
		wb(1'h1, tfc_pkg::ADR_CTRL, {29'h0, r});
	endtask : setr

	function automatic int nxt(int v, int s, int lo, int hi);
		return (v + s < lo || v + s > hi) ? v : v + s;
	endfunction : nxt

	function automatic logic [31:0] bcd(int v);
		logic [31:0] r;
		r = 32'h0;
		for (int k = 0; k < tfc_pkg::NUM_DIGITS; k++) begin
			r[4*k+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction : bcd

	// One detent, then the expected value moves; edges refuse the step
	task automatic step(input logic d);
		dir <= d;
		go <= 1'h1;
		@(posedge mclk);
		go <= 1'h0;
		repeat (2) @(posedge mclk);
		while (busy) @(posedge mclk);
		repeat (2) @(posedge mclk);
		if (rate == tfc_pkg::RATE_BFO)
			off = nxt(off, d ? 1 : -1, -80, 80);
		else
			f10 = nxt(f10, d ? 10 ** rate : -(10 ** rate), 0, 2999999);
	endtask : step

	task automatic sweep(input logic d, input int n);
		for (int k = 0; k < 2 * n; k++) begin
			if (k % n == 0)
				setr(k < n ? tfc_pkg::RATE_100HZ : tfc_pkg::RATE_10HZ);
			step(d);
		end
	endtask : sweep

	task automatic check_all;
		wb(1'h0, tfc_pkg::ADR_FREQ, 32'h0);
		chk(rd, bcd(f10));
		wb(1'h0, tfc_pkg::ADR_OFFSET, 32'h0);
		chk(rd, off);
		// Registered outputs are read away from the edge that launches them
		@(negedge mclk);
		chk(32'({band_code_msb, band_code_mid, band_code_lsb}), 7 - f10 / 32'h61A80);
		chk(32'(lo1_div), tfc_pkg::LO1_DIV_ZERO + f10 / 32'h3E8);
		chk(32'(lo2_div), tfc_pkg::LO2_DIV_BASE + f10 % 32'h64);
		chk(32'(bfo_div), tfc_pkg::BFO_DIV_ZERO + off);
	endtask : check_all

	task automatic report_and_stop;
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		check_all;
		chk(32'(loop_khz), 32'hD2);
		wb(1'h0, tfc_pkg::ADR_FIXDIV, 32'h0);
		chk(rd, 32'h00640320);
		wb(1'h0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		step(1'h0);
		check_all;
		for (i = 0; i < 40; i++) begin
			setr(3'($random(seed)) & 3'h3);
			step(1'($random(seed)));
			check_all;
		end
		@(posedge mclk);
		preset_in <= 1'h1;
		repeat (2) @(posedge mclk);
		preset_in <= 1'h0;
		repeat (8) @(posedge mclk);
		f10 = 32'h16E360;
		sweep(1'h1, 9);
		check_all;
		chk(32'(loop_khz), 32'hC8);
		setr(tfc_pkg::RATE_10KHZ);
		for (i = 0; i < 1501; i++)
			step(1'h0);
		sweep(1'h0, 10);
		check_all;
		wb(1'h1, tfc_pkg::ADR_CTRL, 32'hB);
		rate = tfc_pkg::RATE_10KHZ;
		f10 = 32'h16E360;
		check_all;
		wb(1'h0, tfc_pkg::ADR_CTRL, 32'h0);
		chk(rd, 32'h3);
		for (i = 0; i < 1500; i++)
			step(1'h1);
		check_all;
		setr(tfc_pkg::RATE_BFO);
		@(negedge mclk);
		chk(32'(bfo_select), 32'h1);
		for (i = 0; i < 255; i++) begin
			step(i < 85);
			if (i == 84 || i == 254)
				check_all;
		end
		setr(tfc_pkg::RATE_10HZ);
		@(negedge mclk);
		chk(32'(bfo_select), 32'h0);
		@(posedge mclk);
		rst_n <= 1'h0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		f10 = 32'h16E360;
		off = 0;
		rate = 3'h0;
		check_all;
		report_and_stop;
	end

	// A full run needs well under half of this span
	initial begin
		#1ms;
		error_cnt++;
		report_and_stop;
	end
endmodule : tuning_frequency_control_tb_top

bind tfc_top tfc_top_properties u_props (.mclk, .rst_n, .knob_dir, .preset_in, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .band_code_msb, .band_code_mid, .band_code_lsb, .bfo_select,
	.tune_dir, .lo1_div, .lo2_div, .loop_khz, .bfo_div);

`default_nettype wire
